// file: core/itd_decoder.sv
// Instruction timing decoder with port read-modify-write control for four ports.
`timescale 1ns/1ns
module itd_decoder (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Instruction presented by the fetch unit.
  input  wire logic        instr_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand1,
  input  wire logic        carry_in,
  input  wire logic [7:0]  acc_in,
  // Decoded timing.
  output logic             instr_ready,
  output logic      [1:0]  instr_len,
  output logic      [3:0]  instr_cycles,
  output logic             instr_done,
  output logic             ext_access,
  // Ports.
  input  wire logic [31:0] port_pins,
  output logic      [31:0] port_latches,
  output logic      [7:0]  port_rd_data
);

  logic       rst_s1_q;
  logic       rst_s2_q;
  logic [1:0] len_d;
  logic [3:0] cyc_d;
  logic [1:0] len_q;
  logic [3:0] cyc_q;
  logic [3:0] cnt_q;
  logic       ext_d;
  logic       ext_q;
  logic       busy_q;
  logic       done_q;
  logic       is_rmw;
  logic       is_bitwr;
  logic       is_bitrd;
  logic       bit_val;
  logic [7:0] port_addr;
  logic [2:0] bit_sel;
  logic [1:0] port_idx;
  logic       port_hit;
  logic [7:0] rd_vec [4];
  logic [7:0] wr_data;

  // Reset release through two flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Length and cycle lookup per opcode; groups follow the opcode map rows.
  always_comb begin
    len_d = itd_pkg::LEN_1;
    cyc_d = itd_pkg::CYC_1;
    ext_d = 1'b0;
    unique casez (opcode)
      8'h03, 8'h13, 8'h23, 8'h33: begin
        len_d = itd_pkg::LEN_1; cyc_d = itd_pkg::CYC_1;
      end
      8'b1110_1???, 8'b1111_1???: cyc_d = itd_pkg::CYC_1;
      8'he6, 8'he7, 8'hf6, 8'hf7: cyc_d = itd_pkg::CYC_2;
      8'h85, 8'h75: begin
        len_d = itd_pkg::LEN_3; cyc_d = itd_pkg::CYC_3;
      end
      8'he5, 8'h74, 8'hf5, 8'b0111_1???, 8'b1010_1???, 8'b1000_1???, 8'h76, 8'h77,
      8'h86, 8'h87, 8'ha6, 8'ha7: begin
        len_d = itd_pkg::LEN_2; cyc_d = itd_pkg::CYC_2;
      end
      8'h90: begin
        len_d = itd_pkg::LEN_3; cyc_d = itd_pkg::CYC_3;
      end
      8'h93, 8'h83: cyc_d = itd_pkg::CYC_4;
      8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin
        cyc_d = itd_pkg::CYC_4;
        ext_d = 1'b1;
      end
      8'hc0, 8'hd0: begin
        len_d = itd_pkg::LEN_2; cyc_d = itd_pkg::CYC_2;
      end
      8'b1100_1???: cyc_d = itd_pkg::CYC_1;
      8'hc6, 8'hc7, 8'hd6, 8'hd7: cyc_d = itd_pkg::CYC_2;
      8'hc5: begin
        len_d = itd_pkg::LEN_2; cyc_d = itd_pkg::CYC_2;
      end
      8'hc3, 8'hd3, 8'hb3, 8'h00: cyc_d = itd_pkg::CYC_1;
      8'hc2, 8'hd2, 8'hb2, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'h92: begin
        len_d = itd_pkg::LEN_2; cyc_d = itd_pkg::CYC_2;
      end
      8'h73: cyc_d = itd_pkg::CYC_3;
      8'h02, 8'h12: begin
        len_d = itd_pkg::LEN_3; cyc_d = itd_pkg::CYC_4;
      end
      8'h22, 8'h32: cyc_d = itd_pkg::CYC_4;
      8'b???1_0001, 8'b???0_0001, 8'h80: begin
        len_d = itd_pkg::LEN_2; cyc_d = itd_pkg::CYC_3;
      end
      8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???: begin
        len_d = itd_pkg::LEN_2; cyc_d = itd_pkg::CYC_3;
      end
      8'h20, 8'h30, 8'hb4, 8'hb5, 8'b1011_011?, 8'b1011_1???, 8'hd5: begin
        len_d = itd_pkg::LEN_3; cyc_d = itd_pkg::CYC_4;
      end
      8'h10: begin
        len_d = itd_pkg::LEN_3; cyc_d = itd_pkg::CYC_4;
      end
      8'ha4, 8'h84: cyc_d = itd_pkg::CYC_9;
      8'h52, 8'h42, 8'h62, 8'h05, 8'h15, 8'h24, 8'h34, 8'h94, 8'h54, 8'h44, 8'h64,
      8'h25, 8'h35, 8'h95: begin
        len_d = itd_pkg::LEN_2; cyc_d = itd_pkg::CYC_2;
      end
      8'h53, 8'h43, 8'h63: begin
        len_d = itd_pkg::LEN_3; cyc_d = itd_pkg::CYC_3;
      end
      8'ha3, 8'h06, 8'h07, 8'h16, 8'h17, 8'hd4,
      8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97, 8'h56, 8'h57, 8'h46, 8'h47, 8'h66,
      8'h67: begin
        cyc_d = (opcode == 8'ha3) ? itd_pkg::CYC_3 : itd_pkg::CYC_2;
      end
      default: begin
        len_d = itd_pkg::LEN_1; cyc_d = itd_pkg::CYC_1;
      end
    endcase
  end

  // Port operand classification: destination byte and bit modifies, bit writes, pure pin reads (bit reads and the direct byte read).
  always_comb begin
    is_rmw   = 1'b0;
    is_bitwr = 1'b0;
    is_bitrd = 1'b0;
    bit_val  = 1'b0;
    unique case (opcode)
      8'h52, 8'h42, 8'h62, 8'h53, 8'h43, 8'h63, 8'h05, 8'h15, 8'hd5: is_rmw = 1'b1;
      8'h10, 8'hb2: is_rmw = 1'b1;
      8'h92: begin
        is_bitwr = 1'b1; bit_val = carry_in;
      end
      8'hc2: is_bitwr = 1'b1;
      8'hd2: begin
        is_bitwr = 1'b1; bit_val = 1'b1;
      end
      8'h20, 8'h30, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2, 8'he5: is_bitrd = 1'b1;
      default: is_bitrd = 1'b0;
    endcase
  end

  // Byte opcodes address the port directly; bit opcodes carry port and bit in operand1.
  // The direct byte read samples pins too, but masking its address would alias other registers.
  assign port_addr = (is_bitwr || (is_bitrd && opcode != 8'he5) || opcode == 8'h10 ||
                      opcode == 8'hb2) ? {operand1[7:3], 3'b000} : operand1;
  assign bit_sel   = operand1[2:0];
  assign port_idx  = port_addr[5:4];
  assign port_hit  = (port_addr == itd_pkg::PORT0_ADDR) || (port_addr == itd_pkg::PORT1_ADDR) ||
                     (port_addr == itd_pkg::PORT2_ADDR) || (port_addr == itd_pkg::PORT3_ADDR);
  assign wr_data   = acc_in;

  // One port block per latch; only the addressed one is strobed.
  for (genvar g = 0; g < 4; g++) begin : g_port
    logic sel;
    assign sel = port_hit && (port_idx == 2'(g)) && instr_valid && instr_ready;
    itd_port_rmw u_port (
      .clk       (clk),
      .rst_n     (rst_s2_q),
      .pin_in    (port_pins[8*g +: 8]),
      .latch_out (port_latches[8*g +: 8]),
      .rd_pin    (sel && is_bitrd),
      .rd_latch  (sel && (is_rmw || is_bitwr)),
      .wr_byte   (sel && opcode == 8'hf5),
      .wr_data   (wr_data),
      .wr_bit    (sel && is_bitwr),
      .bit_sel   (bit_sel),
      .bit_val   (bit_val),
      .rd_data   (rd_vec[g])
    );
  end

  // Read data captured into a flop so the data output is registered.
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      port_rd_data <= 8'h00;
    end else if (instr_valid && instr_ready && port_hit) begin
      port_rd_data <= rd_vec[port_idx];
    end
  end

  // Cycle counter: instruction taken when idle, done pulses after its full cycle count.
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
      len_q  <= 2'h0;
      cyc_q  <= 4'h0;
      ext_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q && instr_valid) begin
        len_q  <= len_d;
        cyc_q  <= cyc_d;
        ext_q  <= ext_d;
        cnt_q  <= cyc_d - 4'h1;
        busy_q <= (cyc_d != itd_pkg::CYC_1);
        done_q <= (cyc_d == itd_pkg::CYC_1);
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  // Held values reflect the most recently taken instruction.
  assign instr_ready  = !busy_q;
  assign instr_len    = len_q;
  assign instr_cycles = cyc_q;
  assign instr_done   = done_q;
  assign ext_access   = ext_q;

endmodule // itd_decoder

// file: core/itd_pkg.sv
// Package of instruction lengths, cycle counts, port decode constants and read source and sequencer state types.
//
// Overview of operation
// - Accumulator rotates, plain or through carry, are one byte and one cycle.
// - Accumulator-register moves take one cycle; accumulator-indirect moves take two cycles, one byte.
// - Direct-to-direct and immediate-to-direct moves are three bytes, three cycles; others two.
// - Loading the data pointer with an immediate is three bytes and three cycles.
// - Code memory loads indexed by accumulator are one byte and four cycles.
// - Every extended data move, read or write, takes four cycles.
// - Stack push and pop of a direct byte are two bytes and two cycles.
// - Register exchange takes one cycle; indirect, nibble and direct exchanges take two.
// - Carry-only bit ops are one byte, one cycle; direct-bit ops two bytes, two.
// - Indirect jump via accumulator plus data pointer is one byte, three cycles.
// - Long jump and call are three bytes, four cycles; returns one byte, four.
// - Absolute call, absolute jump and short jump are two bytes, three cycles.
// - Two-byte conditional branches complete in three cycles.
// - Three-byte bit-test, compare and direct decrement branches complete in four cycles.
// - A port bit used purely as an input operand samples the pin.
// - A port destination of a read-modify-write operation reads the output latch.
// - Bit writes to a port read the whole latch byte, change one bit, rewrite.
// - Extended data moves are flagged on ext_access as external data space accesses.
package itd_pkg;

  // Instruction length and cycle count as held by the decoder.
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_9 = 4'h9;

  // Direct addresses of the four port latches and the bit-address base per port.
  localparam logic [7:0] PORT0_ADDR = 8'h80;
  localparam logic [7:0] PORT1_ADDR = 8'h90;
  localparam logic [7:0] PORT2_ADDR = 8'ha0;
  localparam logic [7:0] PORT3_ADDR = 8'hb0;
  localparam logic [7:0] PORT_LATCH_RST = 8'hff;

  // Operand source selection for port reads.
  typedef enum logic [1:0] {
    itd_src_none,
    itd_src_pin,
    itd_src_latch
  } itd_src_e;

  // Timing state of the cycle sequencer.
  typedef enum logic [1:0] {
    itd_st_fetch,
    itd_st_exec,
    itd_st_done
  } itd_state_e;

endpackage : itd_pkg

// file: core/itd_port_rmw.sv
// Port latch with pin-or-latch read selection and bitwise read-modify-write.
`timescale 1ns/1ns
module itd_port_rmw (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Port pins.
  input  wire logic [7:0] pin_in,
  output logic      [7:0] latch_out,
  // Access from the decoder.
  input  wire logic       rd_pin,
  input  wire logic       rd_latch,
  input  wire logic       wr_byte,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_bit,
  input  wire logic [2:0] bit_sel,
  input  wire logic       bit_val,
  output logic      [7:0] rd_data
);

  logic [7:0] latch_q;

  // Bit writes merge into the whole latch byte so other bits keep their latched level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= itd_pkg::PORT_LATCH_RST;
    end else if (wr_byte) begin
      latch_q <= wr_data;
    end else if (wr_bit) begin
      latch_q[bit_sel] <= bit_val;
    end
  end

  // Pure inputs see the pin; modify paths see the latch, avoiding loaded-pin misreads.
  always_comb begin
    if (rd_latch) begin
      rd_data = latch_q;
    end else if (rd_pin) begin
      rd_data = pin_in;
    end else begin
      rd_data = 8'h00;
    end
  end

  assign latch_out = latch_q;

endmodule // itd_port_rmw

// file: tb/itd_decoder_sva.sv
// Assertions on the decoder handshake, cycle counts and port latch traffic.
`timescale 1ns/1ns
module itd_decoder_sva (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rstn,
  // Instruction side.
  input wire logic        instr_valid,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  operand1,
  input wire logic        instr_ready,
  input wire logic [1:0]  instr_len,
  input wire logic [3:0]  instr_cycles,
  input wire logic        instr_done,
  input wire logic        ext_access,
  // Ports.
  input wire logic [31:0] port_pins,
  input wire logic [31:0] port_latches,
  input wire logic [7:0]  port_rd_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  logic       take;
  logic       on_port;
  logic [7:0] addr_q;

  // Operand captured at the take so later checks still know which port bit was meant.
  assign take = instr_valid && instr_ready;
  assign on_port = operand1[7:6] == 2'b10 && !operand1[3];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= 8'h00;
    end else if (take) begin
      addr_q <= operand1;
    end
  end

  // Done is seen on the Nth edge after the take, so N minus one quiet edges come first.
  sequence s_wait1; instr_done; endsequence
  sequence s_wait3; !instr_done [*2] ##1 instr_done; endsequence
  sequence s_wait4; !instr_done [*3] ##1 instr_done; endsequence

  a_rotate_one: assert property (take && opcode inside {8'h03, 8'h13, 8'h33}
    |=> s_wait1)
    else $error("rotate did not finish in one cycle");
  a_jump_ind_three: assert property (take && opcode == 8'h73 |=> s_wait3)
    else $error("indirect jump did not finish in three cycles");
  a_long_four: assert property (take && opcode inside {8'h02, 8'h12, 8'h22, 8'h32}
    |=> s_wait4)
    else $error("long jump or return did not finish in four cycles");
  a_ext_flag: assert property (take && opcode inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3}
    |=> ext_access && instr_cycles == 4'h4)
    else $error("extended move not flagged as four cycles");
  a_decode_stands: assert property (!take
    |=> $stable(instr_len) && $stable(instr_cycles))
    else $error("decoded length or cycles changed without a take");
  a_done_pulse: assert property (instr_done && !take |=> !instr_done)
    else $error("done held longer than one cycle");
  a_done_ready: assert property (instr_done |-> instr_ready)
    else $error("not ready in the done cycle");
  a_bit_clear: assert property (take && opcode == 8'hc2 && on_port
    |-> ##[1:3] !port_latches[{addr_q[5:4], addr_q[2:0]}])
    else $error("cleared port bit not low in latch");
  a_bit_set: assert property (take && opcode == 8'hd2 && on_port
    |-> ##[1:3] port_latches[{addr_q[5:4], addr_q[2:0]}])
    else $error("set port bit not high in latch");
  a_pin_read: assert property (take && opcode == 8'he5 && on_port && operand1[2:0] == 3'h0
    |-> ##[1:3] port_rd_data == port_pins[{addr_q[5:4], 3'h0} +: 8])
    else $error("direct port read did not return pins");
  a_latch_read: assert property (take && opcode == 8'h42 && on_port && operand1[2:0] == 3'h0
    |-> ##[1:3] port_rd_data == port_latches[{addr_q[5:4], 3'h0} +: 8])
    else $error("port logic op did not read the latch");
endmodule // itd_decoder_sva

bind itd_decoder itd_decoder_sva u_sva (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
  .opcode(opcode), .operand1(operand1), .instr_ready(instr_ready), .instr_len(instr_len),
  .instr_cycles(instr_cycles), .instr_done(instr_done), .ext_access(ext_access),
  .port_pins(port_pins), .port_latches(port_latches), .port_rd_data(port_rd_data));

// file: tb/itd_decoder_bench.sv
// Self-checking bench for instruction timing and port latch behaviour.
`timescale 1ns/1ns
module itd_decoder_bench;
  logic        clk, rstn, instr_valid, carry_in, instr_ready, instr_done, ext_access, ext_exp;
  logic [7:0]  opcode, operand1, acc_in, port_rd_data, pa;
  logic [1:0]  instr_len;
  logic [3:0]  instr_cycles;
  logic [31:0] port_pins, port_latches, exp_lat, rnd;
  int          err_total, tests_run, n;
  // Opcode, length and cycles packed as op[15:8] len[7:4] cyc[3:0].
  logic [15:0] tbl [57] = '{16'h0311, 16'h1311, 16'h3311, 16'he811, 16'he612, 16'hf811,
    16'hf612, 16'he522, 16'h7422, 16'h8533, 16'h7533, 16'h9033, 16'h9314, 16'h8314,
    16'he014, 16'he214, 16'hf014, 16'hf214, 16'hc022, 16'hd022, 16'hc811, 16'hc612,
    16'hd612, 16'hc522, 16'hd311, 16'hb311, 16'hc222, 16'hd222, 16'hb222, 16'h8222,
    16'hb022, 16'h7222, 16'ha022, 16'ha222, 16'h9222, 16'h7313, 16'h0234, 16'h1234,
    16'h2214, 16'h3214, 16'h1123, 16'h0123, 16'h8023, 16'h4023, 16'h5023, 16'h6023,
    16'h7023, 16'hd823, 16'h2034, 16'h3034, 16'hb534, 16'hb434, 16'hb834, 16'hb634,
    16'hd534, 16'h1034, 16'he314};

  itd_decoder uut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .opcode(opcode),
    .operand1(operand1), .carry_in(carry_in), .acc_in(acc_in), .instr_ready(instr_ready),
    .instr_len(instr_len), .instr_cycles(instr_cycles), .instr_done(instr_done),
    .ext_access(ext_access), .port_pins(port_pins), .port_latches(port_latches),
    .port_rd_data(port_rd_data));

  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Feedback taps only need a long fixed sequence, not a maximal one.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Counts the comparison and reports a difference.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Issues one instruction and counts edges until done is seen.
  task automatic run(input logic [7:0] op, input logic [7:0] o1);
    @(negedge clk);
    instr_valid = 1'b1;
    opcode = op;
    operand1 = o1;
    @(posedge clk);
    n = 0;
    do begin
      @(negedge clk);
      instr_valid = 1'b0;
      n++;
    end while (instr_done !== 1'b1 && n < 20);
  endtask

  // Runs a port write and compares all four latches one cycle later.
  task automatic wr(input logic [7:0] op, input logic [7:0] o1);
    run(op, o1);
    @(negedge clk);
    chk("port_latches", port_latches, exp_lat);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Generous bound: the whole sequence needs well under a thousand cycles.
  initial begin
    #1000000;
    err_total++;
    conclude();
  end

  initial begin
    {rstn, instr_valid, carry_in, opcode, operand1, acc_in, port_pins} = '0;
    {err_total, tests_run} = '0;
    rnd = 32'h922a;
    exp_lat = 32'hffffffff;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk("reset latches", port_latches, exp_lat);
    // Timing of every class in the overview, with random pins and accumulator that must not matter.
    foreach (tbl[i]) begin
      rnd = lfsr(rnd);
      {port_pins, acc_in, carry_in} = {rnd, rnd[15:8], rnd[3]};
      run(tbl[i][15:8], 8'h00);
      chk("cycles", 32'(n), 32'(tbl[i][3:0]));
      chk("instr_cycles", 32'(instr_cycles), 32'(tbl[i][3:0]));
      chk("instr_len", 32'(instr_len), 32'(tbl[i][7:4]));
      ext_exp = tbl[i][15:8] inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3};
      chk("ext_access", 32'(ext_access), 32'(ext_exp));
    end
    $display("timing table done");
    // Pins are set opposite to the latch after the byte write so a wrong source shows at once.
    for (int p = 0; p < 4; p++) begin
      rnd = lfsr(rnd);
      pa = 8'h80 + 8'(p * 16);
      {acc_in, carry_in} = {rnd[7:0], rnd[8]};
      exp_lat[8 * p +: 8] = rnd[7:0];
      wr(8'hf5, pa);
      port_pins = ~exp_lat;
      exp_lat[8 * p + rnd[11:9]] = 1'b0;
      wr(8'hc2, pa | 8'(rnd[11:9]));
      exp_lat[8 * p + rnd[14:12]] = 1'b1;
      wr(8'hd2, pa | 8'(rnd[14:12]));
      exp_lat[8 * p + rnd[18:16]] = rnd[8];
      wr(8'h92, pa | 8'(rnd[18:16]));
      run(8'he5, pa);
      chk("pin read", 32'(port_rd_data), 32'(port_pins[8 * p +: 8]));
      acc_in = 8'h00;
      run(8'h42, pa);
      chk("latch read", 32'(port_rd_data), 32'(exp_lat[8 * p +: 8]));
      // A byte read of a neighbouring register must not touch the port read value.
      run(8'he5, pa | 8'h01);
      chk("non-port read", 32'(port_rd_data), 32'(exp_lat[8 * p +: 8]));
    end
    $display("port tests done");
    conclude();
  end
endmodule // itd_decoder_bench
